/* File: rtl/fault_pkg.sv */
// Shared constants for the fault aggregator device and host ends
package fault_pkg;

  // ********************************************************
  // Widths
  // ********************************************************
  localparam int ADDR_W = 5; // Register index width
  localparam int DATA_W = 16; // Register data width
  localparam int NUM_CH = 8; // Converter channels
  localparam int NUM_PAIRS = 4; // Saturation channel pairs
  localparam int CH_ERR_W = 8; // Error bits per channel register
  localparam int SAT_ERR_W = 4; // Error bits per saturation register
  localparam int SPI_EXT_W = 2; // External SPI detectors
  localparam int GEN1_W = 4; // SPI fault bits
  localparam int HDR_W = 8; // Conversion header width
  localparam int CHAN_ID_W = 3; // Channel id in header

  // ********************************************************
  // Register indices
  // ********************************************************
  localparam logic [ADDR_W-1:0] IDX_STATUS1 = 5'h00;
  localparam logic [ADDR_W-1:0] IDX_STATUS2 = 5'h01;
  localparam logic [ADDR_W-1:0] IDX_STATUS3 = 5'h02;
  localparam logic [ADDR_W-1:0] IDX_GEN1 = 5'h03;
  localparam logic [ADDR_W-1:0] IDX_GEN2 = 5'h04;
  localparam logic [ADDR_W-1:0] IDX_CH_BASE = 5'h05;
  localparam logic [ADDR_W-1:0] IDX_SAT_BASE = 5'h0d;
  localparam logic [ADDR_W-1:0] IDX_CONFIG = 5'h11;
  localparam logic [ADDR_W-1:0] IDX_LAST = 5'h11;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int BIT_CHIP_ERR = 15; // Any-error flag in each status
  localparam int BIT_INIT_DONE = 14; // Init done, status three
  localparam int BIT_LOC_GEN1 = 0; // Status three location bits
  localparam int BIT_LOC_GEN2 = 1;
  localparam int BIT_SPI_CRC = 0; // General register one
  localparam int BIT_SPI_CLK = 1;
  localparam int BIT_SPI_BAD_RD = 2;
  localparam int BIT_SPI_BAD_WR = 3;
  localparam int BIT_RESET_SEEN = 0; // General register two
  localparam int BIT_HANDOVER = 1;
  localparam int BIT_EN_CH = 4; // Configuration register
  localparam int BIT_EN_SAT = 5;
  localparam int BIT_QUAL_OFF = 6;
  localparam int BIT_HDR_FAULT = 7; // Header fault bit
  localparam int HDR_CHAN_LSB = 4;

  // ********************************************************
  // Reset values and masks
  // ********************************************************
  localparam logic [DATA_W-1:0] CONFIG_RESET = 16'h003f;
  localparam logic [DATA_W-1:0] CONFIG_MASK = 16'h007f;
  localparam logic [DATA_W-1:0] QUAL_OFF_SET = 16'h0040;

endpackage

/* File: rtl/fault_if.sv */
// Link between the converter fault logic and its host controller
`timescale 1ns/1ps
interface fault_if;
  import fault_pkg::*;
  logic acc_valid; // One register access
  logic acc_write; // Access is a write
  logic [ADDR_W-1:0] acc_addr; // Register index
  logic [DATA_W-1:0] acc_wdata; // Write data
  logic rd_valid; // Read answer strobe
  logic [DATA_W-1:0] rd_data; // Read answer data
  logic fault; // Fault pin, active high
  logic conv_valid; // Conversion header strobe
  logic [HDR_W-1:0] conv_header; // Conversion header
  logic sync_in; // Sync pin level

  // Converter end
  modport device (
    input acc_valid, acc_write, acc_addr, acc_wdata, sync_in,
    output rd_valid, rd_data, fault, conv_valid, conv_header
  );

  // Controller end
  modport host (
    output acc_valid, acc_write, acc_addr, acc_wdata, sync_in,
    input rd_valid, rd_data, fault, conv_valid, conv_header
  );
endinterface

/* File: rtl/fault_device.sv */
// Converter end: collects self-diagnostic faults into pin and header
`timescale 1ns/1ps
module fault_device
  import fault_pkg::*;
#(
  parameter int CH_W = CH_ERR_W,
  parameter int SAT_W = SAT_ERR_W
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  fault_if.device link,
  input wire logic pin_mode_i,
  input wire logic [SPI_EXT_W-1:0] spi_err_i,
  input wire logic [NUM_CH*CH_W-1:0] ch_err_i,
  input wire logic [NUM_PAIRS*SAT_W-1:0] sat_err_i,
  input wire logic handover_fail_i,
  input wire logic init_done_i,
  input wire logic conv_strobe_i,
  input wire logic [CHAN_ID_W-1:0] conv_channel_i,
  output logic use_internal_osc_o
);

  // ********************************************************
  // State
  // ********************************************************
  logic [DATA_W-1:0] config_reg; // Enables and qualifier-off
  logic [GEN1_W-1:0] gen1_reg; // Latched SPI faults
  logic pending_clear_reg; // Pin held until next access
  logic reset_seen_reg; // Reset pulse seen
  logic handover_fault_reg; // Clock handover failed
  logic chip_err_reg; // Any-error flag
  logic sync_last_reg; // Sync pin last level
  logic fault_reg; // Fault pin
  logic osc_reg; // Internal oscillator select
  logic rd_valid_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic conv_valid_reg;
  logic [HDR_W-1:0] conv_header_reg;
  // ********************************************************
  // Decode
  // ********************************************************
  logic spi_mode; // Register control mode
  logic rd; // Read access this cycle
  logic wr; // Write access this cycle
  logic addr_ok; // Index is mapped
  logic rd_gen1;
  logic rd_gen2;
  logic rd_status;
  logic wr_config;
  logic sync_toggle;
  assign spi_mode = ~pin_mode_i;
  assign rd = link.acc_valid & ~link.acc_write;
  assign wr = link.acc_valid & link.acc_write;
  assign addr_ok = link.acc_addr <= IDX_LAST;
  assign rd_gen1 = rd & (link.acc_addr == IDX_GEN1);
  assign rd_gen2 = rd & (link.acc_addr == IDX_GEN2);
  assign rd_status = rd & (link.acc_addr <= IDX_STATUS3);
  assign wr_config = wr & spi_mode & (link.acc_addr == IDX_CONFIG);
  assign sync_toggle = link.sync_in ^ sync_last_reg;

  // ********************************************************
  // Live detector sources
  // ********************************************************
  logic [CH_W-1:0] ch_live [NUM_CH]; // Enabled channel faults
  logic [SAT_W-1:0] sat_live [NUM_PAIRS]; // Enabled saturation
  logic [NUM_CH-1:0] loc_channel; // Channel location bits
  logic [NUM_PAIRS-1:0] loc_saturation; // Pair location bits
  logic loc_general_one;
  logic loc_general_two;
  // Masking at the source keeps a disabled detector out of every flag
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign ch_live[gi] = ch_err_i[gi*CH_W +: CH_W]
                           & {CH_W{config_reg[BIT_EN_CH]}};
      assign loc_channel[gi] = |ch_live[gi];
    end
    for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_sat
      assign sat_live[gi] = sat_err_i[gi*SAT_W +: SAT_W]
                            & {SAT_W{config_reg[BIT_EN_SAT]}};
      assign loc_saturation[gi] = |sat_live[gi];
    end
  endgenerate

  // SPI sources, two detected here from the access decode
  logic [GEN1_W-1:0] spi_src;
  always_comb begin
    spi_src = '0;
    spi_src[BIT_SPI_CRC] = spi_err_i[BIT_SPI_CRC];
    spi_src[BIT_SPI_CLK] = spi_err_i[BIT_SPI_CLK];
    spi_src[BIT_SPI_BAD_RD] = rd & ~addr_ok;
    spi_src[BIT_SPI_BAD_WR] = wr & ~addr_ok;
    // Pin mode leaves the SPI detectors off
    spi_src = spi_src & config_reg[GEN1_W-1:0]
              & {GEN1_W{spi_mode}};
  end
  assign loc_general_one = |gen1_reg;
  assign loc_general_two = reset_seen_reg | handover_fault_reg;
  logic any_err; // Any internal error bit
  assign any_err = loc_general_one | loc_general_two
                   | (|loc_channel) | (|loc_saturation);

  // ********************************************************
  // Configuration register
  // ********************************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      config_reg <= CONFIG_RESET;
    end else if (wr_config) begin
      config_reg <= link.acc_wdata & CONFIG_MASK;
    end
  end

  // ********************************************************
  // Latched SPI faults
  // ********************************************************
  // New events win over the clearing read in the same cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gen1_reg <= '0;
    end else begin
      gen1_reg <= (gen1_reg & ~{GEN1_W{rd_gen1}}) | spi_src;
    end
  end

  // Pin stays up after the clearing read until the next access
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pending_clear_reg <= 1'b0;
    end else if (rd_gen1 && loc_general_one) begin
      pending_clear_reg <= 1'b1;
    end else if (link.acc_valid) begin
      pending_clear_reg <= 1'b0;
    end
  end

  // ********************************************************
  // General register two
  // ********************************************************
  // Reset itself loads the flag, so every reset pulse is recorded
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reset_seen_reg <= 1'b1;
    end else if (sync_toggle) begin
      reset_seen_reg <= 1'b0;
    end else if (rd_gen2 && spi_mode) begin
      reset_seen_reg <= 1'b0;
    end
  end

  // Sync pin edge detect
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_last_reg <= 1'b0;
    end else begin
      sync_last_reg <= link.sync_in;
    end
  end
  // Handover fault; a qualifier that is off cannot flag a slow clock
  logic handover_set;
  logic handover_fault_next;
  assign handover_set = handover_fail_i & spi_mode
                        & ~config_reg[BIT_QUAL_OFF];
  assign handover_fault_next = handover_set
    | (handover_fault_reg
       & ~(wr_config & link.acc_wdata[BIT_QUAL_OFF]));
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      handover_fault_reg <= 1'b0;
      osc_reg <= 1'b0;
    end else begin
      handover_fault_reg <= handover_fault_next;
      osc_reg <= handover_fault_next;
    end
  end

  // ********************************************************
  // Any-error flag
  // ********************************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chip_err_reg <= 1'b0;
    end else begin
      chip_err_reg <= any_err | (chip_err_reg & ~rd_status);
    end
  end

  // ********************************************************
  // Fault pin and header
  // ********************************************************
  // Registered so the pin never glitches; live sources fall away alone
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= any_err | pending_clear_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conv_valid_reg <= 1'b0;
      conv_header_reg <= '0;
    end else begin
      conv_valid_reg <= conv_strobe_i;
      if (conv_strobe_i) begin
        conv_header_reg <= '0;
        conv_header_reg[BIT_HDR_FAULT] <= fault_reg;
        conv_header_reg[HDR_CHAN_LSB +: CHAN_ID_W] <= conv_channel_i;
      end
    end
  end

  // ********************************************************
  // Read mux
  // ********************************************************
  logic [DATA_W-1:0] rd_mux;
  logic [ADDR_W-1:0] ch_idx;
  logic [ADDR_W-1:0] sat_idx;
  assign ch_idx = link.acc_addr - IDX_CH_BASE;
  assign sat_idx = link.acc_addr - IDX_SAT_BASE;
  always_comb begin
    rd_mux = '0;
    if (link.acc_addr == IDX_STATUS1) begin
      rd_mux[NUM_CH-1:0] = loc_channel;
      rd_mux[BIT_CHIP_ERR] = chip_err_reg;
    end else if (link.acc_addr == IDX_STATUS2) begin
      rd_mux[NUM_PAIRS-1:0] = loc_saturation;
      rd_mux[BIT_CHIP_ERR] = chip_err_reg;
    end else if (link.acc_addr == IDX_STATUS3) begin
      rd_mux[BIT_LOC_GEN1] = loc_general_one;
      rd_mux[BIT_LOC_GEN2] = loc_general_two;
      rd_mux[BIT_INIT_DONE] = init_done_i;
      rd_mux[BIT_CHIP_ERR] = chip_err_reg;
    end else if (link.acc_addr == IDX_GEN1) begin
      rd_mux[GEN1_W-1:0] = gen1_reg;
    end else if (link.acc_addr == IDX_GEN2) begin
      rd_mux[BIT_RESET_SEEN] = reset_seen_reg;
      rd_mux[BIT_HANDOVER] = handover_fault_reg;
    end else if (link.acc_addr < IDX_SAT_BASE) begin
      rd_mux[CH_W-1:0] = ch_live[ch_idx[2:0]];
    end else if (link.acc_addr < IDX_CONFIG) begin
      rd_mux[SAT_W-1:0] = sat_live[sat_idx[1:0]];
    end else if (link.acc_addr == IDX_CONFIG) begin
      rd_mux = config_reg;
    end
    // Sources cannot be identified in pin mode
    if (!spi_mode) begin
      rd_mux = '0;
    end
  end

  // Answer taken from state before this cycle's clears
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg <= '0;
    end else begin
      rd_valid_reg <= rd;
      if (rd) begin
        rd_data_reg <= rd_mux;
      end
    end
  end
  assign link.rd_valid = rd_valid_reg;
  assign link.rd_data = rd_data_reg;
  assign link.fault = fault_reg;
  assign link.conv_valid = conv_valid_reg;
  assign link.conv_header = conv_header_reg;
  assign use_internal_osc_o = osc_reg;

endmodule

/* File: rtl/fault_host.sv */
// Controller end: issues register accesses and watches the fault pin
`timescale 1ns/1ps
module fault_host
  import fault_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  fault_if.host link,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic [DATA_W-1:0] cmd_wdata_i,
  input wire logic sync_toggle_i,
  input wire logic slow_clk_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_data_o,
  output logic fault_o,
  output logic conv_valid_o,
  output logic conv_fault_o,
  output logic reset_req_o
);

  // ********************************************************
  // State
  // ********************************************************
  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_WAIT} host_state_type;
  host_state_type state_reg; // Access sequencer
  host_state_type state_next;
  logic acc_valid_reg;
  logic acc_write_reg;
  logic [ADDR_W-1:0] acc_addr_reg;
  logic [DATA_W-1:0] acc_wdata_reg;
  logic sync_reg; // Sync pin level
  logic ready_reg;
  logic rsp_valid_reg;
  logic [DATA_W-1:0] rsp_data_reg;
  logic fault_reg;
  logic conv_valid_reg;
  logic conv_fault_reg;
  logic reset_req_reg;
  logic take; // User command accepted

  assign take = (state_reg == ST_IDLE) & ready_reg & cmd_valid_i;

  // ********************************************************
  // Sequencer
  // ********************************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_BOOT: state_next = ST_IDLE;
      ST_IDLE: begin
        if (take && !cmd_write_i) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (link.rd_valid) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_BOOT;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= (state_next == ST_IDLE) & ~take;
    end
  end

  // ********************************************************
  // Access drive
  // ********************************************************
  // Boot write turns the qualifier off before a slow clock is used
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_valid_reg <= 1'b0;
      acc_write_reg <= 1'b0;
      acc_addr_reg <= '0;
      acc_wdata_reg <= '0;
    end else if (state_reg == ST_BOOT && slow_clk_i) begin
      acc_valid_reg <= 1'b1;
      acc_write_reg <= 1'b1;
      acc_addr_reg <= IDX_CONFIG;
      acc_wdata_reg <= CONFIG_RESET | QUAL_OFF_SET;
    end else if (take) begin
      acc_valid_reg <= 1'b1;
      acc_write_reg <= cmd_write_i;
      acc_addr_reg <= cmd_addr_i;
      acc_wdata_reg <= cmd_wdata_i;
    end else begin
      acc_valid_reg <= 1'b0;
    end
  end

  // Sync pin toggles on each request
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_reg <= 1'b0;
    end else if (sync_toggle_i) begin
      sync_reg <= ~sync_reg;
    end
  end

  // ********************************************************
  // Answers and observation
  // ********************************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= '0;
    end else begin
      rsp_valid_reg <= (state_reg == ST_WAIT) & link.rd_valid;
      if (state_reg == ST_WAIT && link.rd_valid) begin
        rsp_data_reg <= link.rd_data;
      end
    end
  end

  // Without a slow clock a handover fault read from general register two raises the reset request
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reset_req_reg <= 1'b0;
    end else if (state_reg == ST_WAIT && link.rd_valid
                 && acc_addr_reg == IDX_GEN2
                 && link.rd_data[BIT_HANDOVER] && !slow_clk_i) begin
      reset_req_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_reg <= 1'b0;
      conv_valid_reg <= 1'b0;
      conv_fault_reg <= 1'b0;
    end else begin
      fault_reg <= link.fault;
      conv_valid_reg <= link.conv_valid;
      if (link.conv_valid) begin
        conv_fault_reg <= link.conv_header[BIT_HDR_FAULT];
      end
    end
  end

  assign link.acc_valid = acc_valid_reg;
  assign link.acc_write = acc_write_reg;
  assign link.acc_addr = acc_addr_reg;
  assign link.acc_wdata = acc_wdata_reg;
  assign link.sync_in = sync_reg;
  assign cmd_ready_o = ready_reg;
  assign rsp_valid_o = rsp_valid_reg;
  assign rsp_data_o = rsp_data_reg;
  assign fault_o = fault_reg;
  assign conv_valid_o = conv_valid_reg;
  assign conv_fault_o = conv_fault_reg;
  assign reset_req_o = reset_req_reg;

endmodule

/* File: tb/fault_link_props.sv */
// Concurrent checks on the link between converter and controller
`timescale 1ns/1ps
module fault_link_props
  import fault_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic rd_valid,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic fault,
  input wire logic conv_valid,
  input wire logic [HDR_W-1:0] conv_header
);
  // ********************************************************
  // One clock domain, so one default for all
  // ********************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // Every read gets its answer exactly one cycle later
  property p_rd_answer;
    acc_valid && !acc_write |=> rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read unanswered");

  // No answer without a read before it
  property p_rd_cause;
    rd_valid |-> $past(acc_valid && !acc_write);
  endproperty
  a_rd_cause: assert property (p_rd_cause)
    else $error("stray answer");

  // Answer data holds between answers
  property p_rd_hold;
    !rd_valid |-> $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved");

  // Unmapped index reads back as zero
  property p_bad_index;
    acc_valid && !acc_write && acc_addr > IDX_LAST |=> rd_data == '0;
  endproperty
  a_bad_index: assert property (p_bad_index)
    else $error("bad index data");

  // Status three carries only flags, init and two locations
  property p_status3_zero;
    rd_valid && $past(acc_addr) == IDX_STATUS3 |-> rd_data[13:2] == '0;
  endproperty
  a_status3_zero: assert property (p_status3_zero)
    else $error("status3 junk");

  // Header fault bit mirrors the pin at the strobe
  property p_hdr_fault;
    conv_valid |-> conv_header[BIT_HDR_FAULT] == $past(fault);
  endproperty
  a_hdr_fault: assert property (p_hdr_fault)
    else $error("header fault bit");

  // Low header nibble stays clear
  property p_hdr_pad;
    conv_valid |-> conv_header[3:0] == 4'h0;
  endproperty
  a_hdr_pad: assert property (p_hdr_pad)
    else $error("header low nibble");

  // Clearing read of SPI faults keeps the pin up meanwhile
  property p_spi_pending;
    rd_valid && $past(acc_addr) == IDX_GEN1 && rd_data[GEN1_W-1:0] != '0
      |-> fault [*2];
  endproperty
  a_spi_pending: assert property (p_spi_pending)
    else $error("pin dropped");

  // Reset leaves the reset-seen flag, so the pin rises
  property p_reset_seen;
    $rose(rstn_i) |=> fault;
  endproperty
  a_reset_seen: assert property (p_reset_seen)
    else $error("no reset flag");
endmodule

/* File: tb/self_diag_fault_aggregator_tb.sv */
// Self-checking bench: device and host ends joined by the fault link
`timescale 1ns/1ps
module self_diag_fault_aggregator_tb;
  import fault_pkg::*;
  // ********************************************************
  // Stimulus and observed signals
  // ********************************************************
  logic clk_i = 1'h0;
  logic rstn_i = 1'h0; // Held low for the first 8 cycles
  logic pin_mode = 1'h0, ho_fail = 1'h0, init_done = 1'h1;
  logic conv_strobe = 1'h0, sync_toggle = 1'h0, slow_clk = 1'h0;
  logic cmd_valid = 1'h0, cmd_write = 1'h0;
  logic [1:0] spi_err = 2'h0;
  logic [63:0] ch_err = 64'h0;
  logic [15:0] sat_err = 16'h0, cmd_wdata = 16'h0, rsp_data, q;
  logic [4:0] cmd_addr = 5'h0;
  logic [2:0] conv_ch = 3'h0;
  logic use_osc, cmd_ready, rsp_valid, fault_o, conv_valid_o;
  logic conv_fault_o, reset_req;
  int n_errors = 0;
  int checked = 0;
  fault_if link ();

  always #12.5 clk_i = ~clk_i; // 40 MHz

  fault_device u_fault_device (.clk_i(clk_i), .rstn_i(rstn_i), .link(link),
    .pin_mode_i(pin_mode), .spi_err_i(spi_err), .ch_err_i(ch_err),
    .sat_err_i(sat_err), .handover_fail_i(ho_fail), .init_done_i(init_done),
    .conv_strobe_i(conv_strobe), .conv_channel_i(conv_ch),
    .use_internal_osc_o(use_osc));
  fault_host u_fault_host (.clk_i(clk_i), .rstn_i(rstn_i), .link(link),
    .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr),
    .cmd_wdata_i(cmd_wdata), .sync_toggle_i(sync_toggle),
    .slow_clk_i(slow_clk), .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data), .fault_o(fault_o), .conv_valid_o(conv_valid_o),
    .conv_fault_o(conv_fault_o), .reset_req_o(reset_req));
  fault_link_props u_fault_link_props (.clk_i(clk_i), .rstn_i(rstn_i),
    .acc_valid(link.acc_valid), .acc_write(link.acc_write),
    .acc_addr(link.acc_addr), .rd_valid(link.rd_valid),
    .rd_data(link.rd_data), .fault(link.fault), .conv_valid(link.conv_valid),
    .conv_header(link.conv_header));

  // ********************************************************
  // Shared tasks
  // ********************************************************
  // Inputs move 2 ns after the edge, clear of the sampling instant
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task fck(input logic e);
    chk("fault pin", {15'h0, link.fault}, {15'h0, e});
  endtask
  // One user command; bounded waits so a stuck host cannot hang us
  task acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    int k;
    k = 0;
    while (cmd_ready !== 1'h1 && k < 50) begin
      tick(1);
      k++;
    end
    cmd_valid = 1'h1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    tick(1);
    cmd_valid = 1'h0;
    while (!w && rsp_valid !== 1'h1 && k < 100) begin
      tick(1);
      k++;
    end
    q = rsp_data;
    if (k >= 50) n_errors++; // Host not ready or not answering within 50 waited cycles
    tick(w ? 2 : 1);
  endtask
  task rdc(input string nm, input logic [4:0] a, input logic [15:0] e);
    acc(1'h0, a, 16'h0);
    chk(nm, q, e);
  endtask
  // Header strobe; fault state must be steady around it
  task hdr(input logic [2:0] c, input logic e);
    conv_ch = c;
    conv_strobe = 1'h1;
    tick(1);
    conv_strobe = 1'h0;
    chk("header", {7'h0, link.conv_valid, link.conv_header},
      {7'h0, 1'h1, e, c, 4'h0});
    tick(1);
    chk("conv fault", {15'h0, conv_fault_o}, {15'h0, e});
    // Host copies of strobe and pin, one cycle behind the link
    chk("host", {14'h0, conv_valid_o, fault_o}, {14'h0, 1'h1, e});
  endtask
  task do_reset();
    rstn_i = 1'h0;
    tick(8);
    rstn_i = 1'h1;
    tick(2);
  endtask
  task pulse_sync();
    sync_toggle = 1'h1;
    tick(1);
    sync_toggle = 1'h0;
    tick(4);
  endtask

  // ********************************************************
  // Scenarios
  // ********************************************************
  task t_boot();
    fck(1'h1);
    rdc("status3", IDX_STATUS3, 16'hc002);
    rdc("gen2", IDX_GEN2, 16'h0001);
    rdc("gen2 again", IDX_GEN2, 16'h0000);
    tick(3);
    fck(1'h0);
    rdc("status3 old", IDX_STATUS3, 16'hc000);
    rdc("status3 new", IDX_STATUS3, 16'h4000);
    init_done = 1'h0;
    rdc("not ready", IDX_STATUS3, 16'h0000);
    init_done = 1'h1;
  endtask
  task t_chan();
    ch_err[17] = 1'h1; // Channel 2, bit 1
    tick(3);
    fck(1'h1);
    hdr(3'h5, 1'h1);
    rdc("status1", IDX_STATUS1, 16'h8004);
    rdc("ch2", IDX_CH_BASE + 5'h2, 16'h0002);
    ch_err[17] = 1'h0;
    tick(3);
    fck(1'h0);
    hdr(3'h2, 1'h0);
    rdc("status1 old", IDX_STATUS1, 16'h8000);
    acc(1'h1, IDX_CONFIG, 16'h002f); // Channel detectors off
    ch_err[0] = 1'h1;
    sat_err[13] = 1'h1; // Pair 3 stays enabled
    tick(3);
    fck(1'h1);
    rdc("status1 off", IDX_STATUS1, 16'h8000);
    rdc("status2", IDX_STATUS2, 16'h8008);
    ch_err = 64'h0;
    sat_err = 16'h0;
    acc(1'h1, IDX_CONFIG, CONFIG_RESET);
  endtask
  task t_spi();
    spi_err = 2'h3; // Both external detectors at once
    tick(1);
    spi_err = 2'h0;
    rdc("bad index", 5'h1f, 16'h0000);
    acc(1'h1, 5'h1e, 16'h0000);
    tick(4);
    fck(1'h1);
    rdc("gen1", IDX_GEN1, 16'h000f);
    tick(6);
    fck(1'h1);
    rdc("gen1 clear", IDX_GEN1, 16'h0000);
    tick(3);
    fck(1'h0);
  endtask
  task t_clk();
    ho_fail = 1'h1;
    tick(1);
    ho_fail = 1'h0;
    tick(2);
    chk("osc", {15'h0, use_osc}, 16'h0001);
    rdc("gen2 handover", IDX_GEN2, 16'h0002);
    tick(2);
    chk("reset req", {15'h0, reset_req}, 16'h0001);
    acc(1'h1, IDX_CONFIG, CONFIG_RESET | QUAL_OFF_SET);
    chk("osc off", {15'h0, use_osc}, 16'h0000);
    rdc("gen2 none", IDX_GEN2, 16'h0000);
  endtask
  task t_mode();
    pin_mode = 1'h1;
    do_reset();
    // A register read must not clear the flag in pin mode
    rdc("pin read", IDX_GEN2, 16'h0000);
    ho_fail = 1'h1;
    tick(1);
    ho_fail = 1'h0;
    tick(2);
    chk("pin osc", {15'h0, use_osc}, 16'h0000);
    fck(1'h1);
    pulse_sync();
    fck(1'h0);
    pin_mode = 1'h0;
    slow_clk = 1'h1; // Host boot write turns the qualifier off
    do_reset();
    ho_fail = 1'h1;
    tick(1);
    ho_fail = 1'h0;
    tick(2);
    chk("slow osc", {15'h0, use_osc}, 16'h0000);
    rdc("slow config", IDX_CONFIG, CONFIG_RESET | QUAL_OFF_SET);
    pulse_sync();
    fck(1'h0);
    rdc("gen2 sync", IDX_GEN2, 16'h0000);
  endtask

  // ********************************************************
  // Run control
  // ********************************************************
  task end_sim();
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    do_reset();
    t_boot();
    t_chan();
    t_spi();
    t_clk();
    t_mode();
    end_sim();
  end
  // Whole run needs well under 1000 cycles
  initial begin
    #(25 * 4000);
    n_errors++;
    end_sim();
  end
endmodule
